//--- design/dac_i2c_slave.sv
// What this block does
// R01: Slave works at 100 kHz and 400 kHz bus rates.
// R02: Only 7-bit addresses match; 10-bit and general call ignored.
// R03: Address is 10011, then select pin level, then 0.
// R04: Matching address is acknowledged low in ninth pulse; otherwise stay idle.
// R05: Each byte is eight bits MSB first plus one acknowledge bit.
// R06: Transmitter changes SDA only while SCL low, except start and stop.
// R07: Master ends a write with stop during the tenth pulse.
// R08: Write frame is address, command, data high, data low; all acknowledged.
// R09: Command 1 loads input register at either load strobe level.
// R10: Command 2 copies input to DAC register; command 0 does nothing.
// R11: Command 3 loads DAC and input registers with the same word.
// R12: Data is left aligned; unused low bits and low command nibble ignored.
// R13: Command 4 takes control bits from data bits 15 down to 11.
// R14: Gain bit 0 gives span to reference, 1 twice reference.
// R15: Reference bit 0 keeps reference on, 1 turns it off.
// R16: Power-down code picks output load and disables buffer, reference stays.
// R17: Power-down keeps the DAC register and still accepts updates.
// R18: Leaving power-down takes 4 us, or 600 us with reference off.
// R19: Software reset clears input, DAC and control, then self-clears.
// R20: Read address is acknowledged, then input register sent high byte first.
// R21: Master does not acknowledge the last read byte, then stops.
// R22: Load strobe low during input write updates DAC at last data edge.
// R23: Load strobe falling after stop copies input to DAC; ignored while busy.
// R24: Read-back uses written alignment with unused low bits as zero.
`timescale 1ns/100ps
module dac_i2c_slave
   import dac_i2c_pkg::*;
#(
   parameter int RES_BITS = 16,
   parameter int PD_EXIT_REF_OFF_CYCLES = PD_EXIT_REF_OFF_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic load_strobe_n,
   input wire logic addr_select_pin,
   output logic [15:0] dac_code,
   output logic gain_x2,
   output logic ref_disable,
   output logic powerdown_sel_hi,
   output logic powerdown_sel_lo,
   output logic out_buffer_en,
   output logic pd_exit_busy
);
   // Zero the low bits that a reduced-resolution converter does not use.
   function automatic logic [15:0] mask_code(input logic [15:0] w);
      logic [15:0] m;
      m = 16'hFFFF << (DATA_W - RES_BITS);
      return w & m;
   endfunction : mask_code

   // Odd byte slots of a read carry the high byte, even slots the low byte.
   function automatic logic [7:0] tx_pick(input logic [2:0] idx, input logic [15:0] w);
      return idx[0] ? w[15:8] : w[7:0];
   endfunction : tx_pick

   logic [3:0] pins_s;
   logic scl_s, sda_s, load_strobe_n_s, a0_s;
   logic scl_q_ff, sda_q_ff, load_strobe_n_q_ff;
   logic scl_rise, scl_fall, start_det, stop_det, load_strobe_n_fall, frame_done;
   i2c_state_e state_ff;
   logic [2:0] bit_cnt_ff, byte_idx_ff, next_idx;
   logic [7:0] shift_ff, cmd_ff, data_hi_ff, next_tx;
   logic rw_ff, a0_ff, busy_ff, sda_oe_ff, sda_out_ff, rise_seen_ff;
   logic [6:0] own_addr;
   logic [15:0] raw_word, rx_word, input_code_holding_ff, dac_reg_ff;
   logic [4:0] control_settings_ff;
   logic [1:0] pd_prev_ff;
   logic [EXIT_W-1:0] exit_cnt_ff;
   logic out_buf_en_ff, pd_exit_busy_ff;

   // Every pin from outside is resynchronised; the core clock oversamples SCL
   // far beyond fast-mode rates, so both bus speeds are handled alike.
   pin_sync3 #(
      .WIDTH(4),
      .RESET_VAL(4'hE)
   ) u_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .din({scl_in, sda_in, load_strobe_n, addr_select_pin}),
      .dout(pins_s)
   ); // R01

   assign scl_s = pins_s[3];
   assign sda_s = pins_s[2];
   assign load_strobe_n_s = pins_s[1];
   assign a0_s = pins_s[0];

   // Previous samples for edge detection on the filtered lines.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         load_strobe_n_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         load_strobe_n_q_ff <= load_strobe_n_s;
      end
   end

   // SDA moving while SCL stays high is only legal as start or stop.
   assign scl_rise = scl_s & ~scl_q_ff;
   assign scl_fall = ~scl_s & scl_q_ff;
   assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s; // R06
   assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s; // R07
   assign load_strobe_n_fall = ~load_strobe_n_s & load_strobe_n_q_ff;

   // Extended and general-call addresses can never equal this pattern.
   assign own_addr = {ADDR_FIXED_HI, a0_ff, ADDR_FIXED_LSB}; // R03 R02

   // The last data bit of the low byte has just been shifted in.
   assign frame_done = (state_ff == ST_RX) && scl_fall && (bit_cnt_ff == LAST_BIT)
      && (byte_idx_ff == IDX_LO) && rise_seen_ff; // R08
   assign raw_word = {data_hi_ff, shift_ff};
   assign rx_word = mask_code(raw_word); // R12
   assign next_idx = byte_idx_ff + 3'h1;
   assign next_tx = tx_pick(next_idx, input_code_holding_ff); // R20 R24

   // Bus activity window; the select pin is caught at each start so that it
   // may be changed between transfers.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_ff <= 1'b0;
         a0_ff <= 1'b0;
      end else if (stop_det) begin
         busy_ff <= 1'b0;
      end else if (start_det) begin
         busy_ff <= 1'b1;
         a0_ff <= a0_s;
      end
   end

   // Byte engine. A start or stop aborts whatever is in progress. Only an SCL
   // fall after a rise ends a bit, so the fall closing a start is not counted.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         byte_idx_ff <= IDX_ADDR;
         shift_ff <= 8'h00;
         cmd_ff <= 8'h00;
         data_hi_ff <= 8'h00;
         rw_ff <= 1'b0;
         rise_seen_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
         sda_oe_ff <= 1'b0;
      end else if (start_det) begin
         state_ff <= ST_RX;
         bit_cnt_ff <= 3'h0;
         byte_idx_ff <= IDX_ADDR;
         rise_seen_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else begin
         rise_seen_ff <= scl_rise | (rise_seen_ff & ~scl_fall);
         case (state_ff)
            ST_IDLE: begin
               sda_oe_ff <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_s}; // R05
               end
               if (scl_fall && rise_seen_ff) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == LAST_BIT) begin
                     if (byte_idx_ff == IDX_ADDR) begin
                        if (shift_ff[7:1] == own_addr) begin
                           rw_ff <= shift_ff[0];
                           sda_oe_ff <= 1'b1; // R04
                           state_ff <= ST_ACK;
                        end else begin
                           state_ff <= ST_IDLE; // R04
                        end
                     end else if (byte_idx_ff <= IDX_LO) begin
                        if (byte_idx_ff == IDX_CMD) begin
                           cmd_ff <= shift_ff;
                        end
                        if (byte_idx_ff == IDX_HI) begin
                           data_hi_ff <= shift_ff;
                        end
                        sda_oe_ff <= 1'b1; // R08
                        state_ff <= ST_ACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
            end
            ST_ACK: begin
               // Release or start sending on the falling edge ending the ninth pulse.
               if (scl_fall) begin
                  bit_cnt_ff <= 3'h0;
                  byte_idx_ff <= next_idx;
                  if (rw_ff) begin
                     shift_ff <= next_tx;
                     sda_oe_ff <= ~next_tx[7]; // R20
                     state_ff <= ST_TX;
                  end else begin
                     sda_oe_ff <= 1'b0;
                     state_ff <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               // Data only changes after SCL has fallen, keeping the high phase clean.
               if (scl_fall) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == LAST_BIT) begin
                     sda_oe_ff <= 1'b0;
                     state_ff <= ST_TX_ACK;
                  end else begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     sda_oe_ff <= ~shift_ff[6]; // R05
                  end
               end
            end
            ST_TX_ACK: begin
               // A high acknowledge ends the read; the stop follows from the master.
               if (scl_rise && sda_s) begin
                  state_ff <= ST_IDLE; // R21
               end else if (scl_fall) begin
                  bit_cnt_ff <= 3'h0;
                  byte_idx_ff <= next_idx;
                  shift_ff <= next_tx;
                  sda_oe_ff <= ~next_tx[7];
                  state_ff <= ST_TX;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain line: the output level is always low, only the enable moves.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out_ff <= 1'b0;
      end else begin
         sda_out_ff <= 1'b0;
      end
   end

   // Commands act at the last data bit; an idle strobe fall copies input to DAC.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         input_code_holding_ff <= INPUT_RESET;
         dac_reg_ff <= DAC_RESET;
         control_settings_ff <= CONTROL_RESET;
      end else if (frame_done) begin
         case (cmd_ff[7:4])
            CMD_WRITE_INPUT: begin
               input_code_holding_ff <= rx_word; // R09
               if (!load_strobe_n_s) begin
                  dac_reg_ff <= rx_word; // R22
               end
            end
            CMD_UPDATE_DAC: begin
               dac_reg_ff <= input_code_holding_ff; // R10
            end
            CMD_WRITE_DAC_INPUT: begin
               dac_reg_ff <= rx_word; // R11
               input_code_holding_ff <= rx_word; // R11
            end
            CMD_WRITE_CONTROL: begin
               if (raw_word[CTRL_RESET_BIT]) begin
                  input_code_holding_ff <= INPUT_RESET; // R19
                  dac_reg_ff <= DAC_RESET; // R19
                  control_settings_ff <= CONTROL_RESET; // R19
               end else begin
                  // Low data bits are ignored; the reset bit never stays set.
                  control_settings_ff <= {1'b0, raw_word[CTRL_PD_HI_BIT],
                     raw_word[CTRL_PD_LO_BIT], raw_word[REFERENCE_BIT_POSITION],
                     raw_word[CTRL_GAIN_BIT]}; // R13
               end
            end
            default: begin
               // No-op and unused codes leave everything as it is.
            end
         endcase
      end else if (load_strobe_n_fall && !busy_ff) begin
         dac_reg_ff <= input_code_holding_ff; // R23
      end
   end

   // Power-down exit wait. Going back to normal mode holds the buffer off
   // for the settle time, which is far longer with the reference off.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_prev_ff <= PD_NORMAL;
         exit_cnt_ff <= '0;
      end else begin
         pd_prev_ff <= control_settings_ff[CS_PD_HI:CS_PD_LO];
         if (pd_prev_ff != PD_NORMAL && control_settings_ff[CS_PD_HI:CS_PD_LO] == PD_NORMAL) begin
            exit_cnt_ff <= control_settings_ff[CS_REF] ? EXIT_W'(PD_EXIT_REF_OFF_CYCLES)
               : EXIT_W'(PD_EXIT_CYC); // R18
         end else if (exit_cnt_ff != '0) begin
            exit_cnt_ff <= exit_cnt_ff - EXIT_W'(1);
         end
      end
   end

   // Buffer enable in normal mode with no wait counting, so it is on for one cycle before the wait loads; the DAC register is
   // untouched by power-down and keeps accepting writes meanwhile.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_buf_en_ff <= 1'b1;
         pd_exit_busy_ff <= 1'b0;
      end else begin
         out_buf_en_ff <= (control_settings_ff[CS_PD_HI:CS_PD_LO] == PD_NORMAL)
            && (exit_cnt_ff == '0); // R16 R17
         pd_exit_busy_ff <= exit_cnt_ff != '0; // R18
      end
   end

   assign sda_out = sda_out_ff;
   assign sda_oe = sda_oe_ff;
   assign dac_code = dac_reg_ff;
   assign gain_x2 = control_settings_ff[CS_GAIN]; // R14
   assign ref_disable = control_settings_ff[CS_REF]; // R15
   assign powerdown_sel_hi = control_settings_ff[CS_PD_HI]; // R16
   assign powerdown_sel_lo = control_settings_ff[CS_PD_LO]; // R16
   assign out_buffer_en = out_buf_en_ff;
   assign pd_exit_busy = pd_exit_busy_ff;
endmodule : dac_i2c_slave

//--- design/dac_i2c_pkg.sv
package dac_i2c_pkg;
   // Core clock period and the derived power-down exit waits.
   localparam int CLK_PERIOD_NS = 8;
   localparam int PD_EXIT_NS = 4000;
   localparam int PD_EXIT_REF_OFF_NS = 600000;
   localparam int PD_EXIT_CYC = (PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PD_EXIT_REF_OFF_CYC =
      (PD_EXIT_REF_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXIT_W = 17;

   // Slave address pieces: fixed upper bits, select pin, fixed low bit.
   localparam logic [4:0] ADDR_FIXED_HI = 5'h13;
   localparam logic ADDR_FIXED_LSB = 1'b0;

   // Upper command nibble values.
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
   localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
   localparam logic [3:0] CMD_WRITE_DAC_INPUT = 4'h3;
   localparam logic [3:0] CMD_WRITE_CONTROL = 4'h4;

   // Control bit positions within the data word.
   localparam int CTRL_RESET_BIT = 15;
   localparam int CTRL_PD_HI_BIT = 14;
   localparam int CTRL_PD_LO_BIT = 13;
   localparam int REFERENCE_BIT_POSITION = 12;
   localparam int CTRL_GAIN_BIT = 11;

   // Field positions inside the stored control_settings register.
   localparam int CS_GAIN = 0;
   localparam int CS_REF = 1;
   localparam int CS_PD_LO = 2;
   localparam int CS_PD_HI = 3;
   localparam int CS_RESET = 4;

   // Values after reset.
   localparam logic [15:0] INPUT_RESET = 16'h0000;
   localparam logic [15:0] DAC_RESET = 16'h0000;
   localparam logic [4:0] CONTROL_RESET = 5'h00;
   localparam logic [1:0] PD_NORMAL = 2'h0;

   // Frame layout: address byte is index zero, then command, high, low.
   localparam int DATA_W = 16;
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_CMD = 3'h1;
   localparam logic [2:0] IDX_HI = 3'h2;
   localparam logic [2:0] IDX_LO = 3'h3;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_TX_ACK = 5'h10
   } i2c_state_e;
endpackage : dac_i2c_pkg

//--- design/pin_sync3.sv
`timescale 1ns/100ps
module pin_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] out_ff;

   // Three stages; a bit only moves once stages two and three agree, which
   // also filters single-sample glitches on the slow bus lines.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
         out_ff <= RESET_VAL;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               out_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   assign dout = out_ff;
endmodule : pin_sync3

//--- bench/dac_i2c_slave_monitor.sv
`timescale 1ns/100ps
module dac_i2c_slave_monitor
   import dac_i2c_pkg::*;
#(
   parameter int RES_BITS = 16,
   parameter int PD_EXIT_REF_OFF_CYCLES = PD_EXIT_REF_OFF_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic load_strobe_n,
   input wire logic [15:0] dac_code,
   input wire logic gain_x2,
   input wire logic ref_disable,
   input wire logic powerdown_sel_hi,
   input wire logic powerdown_sel_lo,
   input wire logic out_buffer_en,
   input wire logic pd_exit_busy
);
   // Length of the running power-down exit wait, so its exact figure can be judged.
   logic [19:0] busy_cnt_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_ff <= 20'h00000;
      end else if (pd_exit_busy) begin
         busy_cnt_ff <= busy_cnt_ff + 20'h00001;
      end else begin
         busy_cnt_ff <= 20'h00000;
      end
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // The slave may only move SDA in the low phase, so a stop is never faked.
   sda_low_phase_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("SDA drive changed while SCL high");
   drive_low_only_a: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("SDA driven high");
   ack_holds_a: assert property ($rose(sda_oe) |=> sda_oe [*4])
      else $error("SDA pull released too early");
   pd_no_buf_a: assert property ((powerdown_sel_hi || powerdown_sel_lo) |=> !out_buffer_en)
      else $error("Output buffer on in power-down");
   exit_len_a: assert property ($fell(pd_exit_busy) |->
      int'(busy_cnt_ff) == (ref_disable ? PD_EXIT_REF_OFF_CYCLES : PD_EXIT_CYC))
      else $error("Power-down exit wait has wrong length");
   exit_start_a: assert property ($fell(powerdown_sel_hi || powerdown_sel_lo)
      |-> ##[0:2] pd_exit_busy)
      else $error("No exit wait after leaving power-down");
   buf_after_exit_a: assert property ($fell(pd_exit_busy) |=> out_buffer_en)
      else $error("Buffer not enabled after exit wait");
   busy_no_buf_a: assert property (pd_exit_busy |-> !out_buffer_en)
      else $error("Buffer on during exit wait");
   ctrl_low_phase_a: assert property ($changed({gain_x2, ref_disable}) |-> !scl_in)
      else $error("Control bits changed outside SCL low");
   dac_cause_a: assert property ($changed(dac_code) && scl_in |-> !load_strobe_n)
      else $error("DAC register changed without cause");

   // Main scenarios reached.
   cover property ($rose(sda_oe));
   cover property ($fell(pd_exit_busy) && ref_disable);
   cover property ($changed(dac_code) && scl_in);
endmodule : dac_i2c_slave_monitor

bind dac_i2c_slave dac_i2c_slave_monitor #(
   .RES_BITS(RES_BITS),
   .PD_EXIT_REF_OFF_CYCLES(PD_EXIT_REF_OFF_CYCLES)
) dac_i2c_slave_monitor_inst (
   .clk(clk),
   .reset_n(reset_n),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .load_strobe_n(load_strobe_n),
   .dac_code(dac_code),
   .gain_x2(gain_x2),
   .ref_disable(ref_disable),
   .powerdown_sel_hi(powerdown_sel_hi),
   .powerdown_sel_lo(powerdown_sel_lo),
   .out_buffer_en(out_buffer_en),
   .pd_exit_busy(pd_exit_busy)
);

//--- bench/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
   input wire logic clk,
   input wire logic sda_oe,
   output logic scl_in,
   output logic sda_in
);
   // Master drive level; the wire has a pull-up, so released means high.
   logic sda_m = 1'b1;
   int q = 20;
   initial scl_in = 1'b1;
   assign sda_in = sda_m & ~sda_oe;

   // Quarter bit periods; the bench sets q to pick the bit rate.
   task automatic qw(input int n);
      repeat (n * q) @(negedge clk);
   endtask : qw

   // Start also serves as a repeated start from the SCL low phase.
   task automatic start();
      sda_m = 1'b1;
      qw(1);
      scl_in = 1'b1;
      qw(1);
      sda_m = 1'b0;
      qw(1);
      scl_in = 1'b0;
      qw(1);
   endtask : start

   task automatic stop();
      sda_m = 1'b0;
      qw(1);
      scl_in = 1'b1;
      qw(1);
      sda_m = 1'b1;
      qw(2);
   endtask : stop

   // SDA moves only in the low phase and is sampled mid-high.
   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      qw(1);
      scl_in = 1'b1;
      qw(1);
      s = sda_in;
      qw(1);
      scl_in = 1'b0;
      qw(1);
   endtask : bit_io

   // Eight bits MSB first, then the acknowledge slot driven as ack_in.
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack);
   endtask : xfer
endmodule : i2c_master_model

//--- bench/dac_i2c_slave_bench.sv
`timescale 1ns/100ps
module dac_i2c_slave_bench
   import dac_i2c_pkg::*;
;
   localparam int REF_OFF_CYC = 600;
   logic clk, reset_n, load_strobe_n, addr_select_pin, scl_in, sda_in, sda_out, sda_oe;
   logic gain_x2, ref_disable, powerdown_sel_hi, powerdown_sel_lo, out_buffer_en;
   logic pd_exit_busy;
   logic [15:0] dac_code;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   dac_i2c_slave #(.RES_BITS(16), .PD_EXIT_REF_OFF_CYCLES(REF_OFF_CYC)) dac_i2c_slave_inst (
      .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .load_strobe_n(load_strobe_n), .addr_select_pin(addr_select_pin),
      .dac_code(dac_code), .gain_x2(gain_x2), .ref_disable(ref_disable),
      .powerdown_sel_hi(powerdown_sel_hi), .powerdown_sel_lo(powerdown_sel_lo),
      .out_buffer_en(out_buffer_en), .pd_exit_busy(pd_exit_busy));
   i2c_master_model i2c_master_model_inst (
      .clk(clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

   // Free-running core clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // A hang is cut short well past the longest expected run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d,
                     output logic [3:0] ak);
      logic [7:0] r;
      i2c_master_model_inst.start();
      i2c_master_model_inst.xfer(a, 1'b1, r, ak[3]);
      i2c_master_model_inst.xfer(c, 1'b1, r, ak[2]);
      i2c_master_model_inst.xfer(d[15:8], 1'b1, r, ak[1]);
      i2c_master_model_inst.xfer(d[7:0], 1'b1, r, ak[0]);
      i2c_master_model_inst.stop();
   endtask : wr

   // Write to the default address; every byte must be acknowledged.
   task automatic w(input logic [7:0] c, input logic [15:0] d);
      logic [3:0] ak;
      wr(8'h98, c, d, ak);
      chk(16'(ak), 16'h0000);
   endtask : w

   // Read back the input register; the master refuses the last byte.
   task automatic rd(input logic [15:0] exp);
      logic [7:0] hi;
      logic [7:0] lo;
      logic ak;
      logic x;
      i2c_master_model_inst.start();
      i2c_master_model_inst.xfer(8'h99, 1'b1, hi, ak);
      i2c_master_model_inst.xfer(8'hFF, 1'b0, hi, x);
      i2c_master_model_inst.xfer(8'hFF, 1'b1, lo, x);
      i2c_master_model_inst.stop();
      chk(16'(ak), 16'h0000);
      chk({hi, lo}, exp);
   endtask : rd

   task automatic wait_exit(output int n);
      n = 0;
      while (pd_exit_busy === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      chk(16'(out_buffer_en), 16'h0001);
   endtask : wait_exit

   task automatic t_input();
      chk(dac_code, 16'h0000);
      chk(16'({gain_x2, ref_disable, powerdown_sel_hi, powerdown_sel_lo}), 16'h0000);
      chk(16'({pd_exit_busy, out_buffer_en}), 16'h0001);
      w(8'h1F, 16'hA5C3);
      chk(dac_code, 16'h0000);
      rd(16'hA5C3);
      w(8'h0F, 16'h5555);
      rd(16'hA5C3);
      w(8'h2A, 16'h1234);
      chk(dac_code, 16'hA5C3);
      i2c_master_model_inst.q = 78;
      w(8'h35, 16'h8001);
      i2c_master_model_inst.q = 20;
      chk(dac_code, 16'h8001);
      rd(16'h8001);
      $display("test commands done");
   endtask : t_input

   task automatic t_addr();
      logic [3:0] ak;
      logic [7:0] bad [3] = '{8'h98, 8'h00, 8'hF0};
      addr_select_pin = 1'b1;
      wr(8'h9C, 8'h30, 16'h0F0F, ak);
      chk(16'(ak), 16'h0000);
      chk(dac_code, 16'h0F0F);
      foreach (bad[i]) begin
         wr(bad[i], 8'h30, 16'hFFFF, ak);
         chk(16'(ak), 16'h000F);
         chk(dac_code, 16'h0F0F);
      end
      addr_select_pin = 1'b0;
      $display("test address done");
   endtask : t_addr

   task automatic t_ctrl();
      int n;
      w(8'h40, 16'h1800);
      chk(16'({gain_x2, ref_disable}), 16'h0003);
      for (int pd = 1; pd < 4; pd++) begin
         w(8'h40, 16'(pd) << 13);
         chk(16'({powerdown_sel_hi, powerdown_sel_lo, out_buffer_en}), 16'(pd << 1));
      end
      w(8'h30, 16'h4444);
      chk(dac_code, 16'h4444);
      w(8'h40, 16'h0000);
      chk(16'(pd_exit_busy), 16'h0001);
      wait_exit(n);
      chk(16'(n inside {[280:380]}), 16'h0001);
      w(8'h40, 16'h3000);
      w(8'h40, 16'h1000);
      wait_exit(n);
      chk(16'(n inside {[380:480]}), 16'h0001);
      w(8'h40, 16'h8800);
      chk(dac_code, 16'h0000);
      chk(16'({gain_x2, ref_disable, powerdown_sel_hi, powerdown_sel_lo}), 16'h0000);
      rd(16'h0000);
      $display("test control done");
   endtask : t_ctrl

   // Strobe pulses inside a frame are dropped; after stop they load the DAC.
   task automatic t_strobe();
      w(8'h10, 16'h7777);
      chk(dac_code, 16'h0000);
      fork
         w(8'h10, 16'h1111);
         begin
            repeat (300) @(negedge clk);
            load_strobe_n = 1'b0;
            repeat (20) @(negedge clk);
            load_strobe_n = 1'b1;
         end
      join
      chk(dac_code, 16'h0000);
      load_strobe_n = 1'b0;
      repeat (20) @(negedge clk);
      chk(dac_code, 16'h1111);
      w(8'h10, 16'h2222);
      chk(dac_code, 16'h2222);
      load_strobe_n = 1'b1;
      $display("test load strobe done");
   endtask : t_strobe

   task automatic final_report();
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // Reset, let the pin synchronisers settle, then run the scenarios.
   initial begin
      reset_n = 1'b0;
      load_strobe_n = 1'b1;
      addr_select_pin = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      t_input();
      t_addr();
      t_ctrl();
      t_strobe();
      final_report();
   end
endmodule : dac_i2c_slave_bench
